/* e1ac_control.sv */
// E1 automatic alarm generation, common control registers and loopback routing
`timescale 1ns/100ps
`default_nettype none
// How it works
// - auto AIS on frame, AIS or carrier loss
// - auto RAI on same, or 128ms MF fail
// - continuous RAI after 400ms MF search
// - bit 7 bypasses or inserts tx elastic store
// - bit 6 picks channel-block or signaling use
// - bit 5 picks idle code or per-channel loop
// - bit 3 reinserts rx signaling into output
// - bit 2 inserts hardware signaling into tx
// - bit 1 declares tx backplane clock rate
// - carrier loss after 255 or 2048 zeros
// - remote loop returns rx line to tx
// - local loop feeds tx data to rx
// - local loop data passes jitter attenuator
// - line ones force sends unframed all ones
// - five-bit field selects monitored tx channel
module e1ac_control #(
  parameter int MF_FIND_CYCLES    = e1ac_pkg::MF_FIND_CYCLES,
  parameter int MF_GIVE_UP_CYCLES = e1ac_pkg::MF_GIVE_UP_CYCLES
) (
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // Register port
  input  wire e1ac_pkg::e1ac_req_s  reg_req,
  output var  logic [7:0]           reg_rdata,
  output var  logic                 irq,
  // Receive framer status
  input  wire logic                 rx_frame_loss,
  input  wire logic                 rx_ais_detect,
  input  wire logic                 rx_crc4_on,
  input  wire logic                 rx_mf_sync,
  // Line side
  input  wire logic                 rx_bit_strobe,
  input  wire e1ac_pkg::e1ac_line_s rx_line_in,
  input  wire logic                 mclk_strobe,
  input  wire e1ac_pkg::e1ac_line_s tx_formatter_in,
  output var  e1ac_pkg::e1ac_line_s tx_line_out,
  output var  e1ac_pkg::e1ac_line_s rx_framer_out,
  output var  e1ac_pkg::e1ac_line_s jitter_att_in,
  input  wire e1ac_pkg::e1ac_line_s jitter_att_out,
  // Transmit backplane data path
  input  wire logic                 tx_serial_in,
  input  wire logic                 tx_signaling_in,
  input  wire logic                 tx_sig_slot,
  input  wire logic                 tx_block_bit,
  input  wire logic                 tx_idle_mark,
  input  wire logic                 tx_idle_code_bit,
  output var  logic                 tx_data_out,
  output var  logic                 tx_channel_block_out,
  // Receive backplane data path
  input  wire logic                 rx_data_in,
  input  wire logic                 rx_sig_slot,
  input  wire logic                 rx_sig_bit,
  output var  logic                 rx_serial_out,
  // Transmit channel monitor feed
  input  wire logic                 tx_chan_valid,
  input  wire logic [4:0]           tx_chan_num,
  input  wire logic [7:0]           tx_chan_byte,
  // Control and alarm outputs
  output var  logic                 tx_elastic_store_on,
  output var  logic                 tx_backplane_clock_rate,
  output var  logic                 tx_ais_send,
  output var  logic                 tx_rai_send,
  output var  logic                 rx_carrier_loss
);
  // ==========================================================
  // Registers
  // ==========================================================
  logic [7:0]                   alarm_ctrl;
  logic [7:0]                   bp_sig_ctrl;
  logic [7:0]                   loop_mon;
  logic [7:0]                   tx_channel_monitor;
  logic [e1ac_pkg::IRQ_BITS-1:0] irq_status;
  logic [e1ac_pkg::IRQ_BITS-1:0] irq_enable;
  logic [e1ac_pkg::IRQ_BITS-1:0] irq_event;
  logic [e1ac_pkg::IRQ_BITS-1:0] irq_clear;

  logic tx_block_reg_function;
  logic tx_idle_reg_function;
  logic rx_signaling_reinsert;
  logic tx_hw_signaling_insert;
  logic carrier_loss_long_criterion;
  logic remote_loop;
  logic local_loop;
  logic line_all_ones_force;
  logic [4:0] tx_monitor_select;

  assign tx_block_reg_function       = bp_sig_ctrl[e1ac_pkg::BIT_TX_BLOCK_FN];
  assign tx_idle_reg_function        = bp_sig_ctrl[e1ac_pkg::BIT_TX_IDLE_FN];
  assign rx_signaling_reinsert       = bp_sig_ctrl[e1ac_pkg::BIT_RX_SIG_REINS];
  assign tx_hw_signaling_insert      = bp_sig_ctrl[e1ac_pkg::BIT_TX_HW_SIG];
  assign carrier_loss_long_criterion = bp_sig_ctrl[e1ac_pkg::BIT_CL_LONG];
  assign remote_loop                 = loop_mon[e1ac_pkg::BIT_REMOTE_LOOP];
  assign local_loop                  = loop_mon[e1ac_pkg::BIT_LOCAL_LOOP];
  assign line_all_ones_force         = loop_mon[e1ac_pkg::BIT_LINE_ONES];
  assign tx_monitor_select = loop_mon[e1ac_pkg::MON_SEL_MSB:e1ac_pkg::MON_SEL_LSB];

  // Control registers: zero after reset, read back as written
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_ctrl  <= e1ac_pkg::RST_ALARM_CTRL;
      bp_sig_ctrl <= e1ac_pkg::RST_BP_SIG_CTRL;
      loop_mon    <= e1ac_pkg::RST_LOOP_MON;
    end else if (reg_req.wr) begin
      if (reg_req.addr == e1ac_pkg::ADDR_ALARM_CTRL) begin
        alarm_ctrl <= reg_req.wdata;
      end else if (reg_req.addr == e1ac_pkg::ADDR_BP_SIG_CTRL) begin
        // Unassigned bit is stored as written; host keeps it zero
        bp_sig_ctrl <= reg_req.wdata;
      end else if (reg_req.addr == e1ac_pkg::ADDR_LOOP_MON) begin
        loop_mon <= reg_req.wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_enable <= e1ac_pkg::RST_IRQ[e1ac_pkg::IRQ_BITS-1:0];
    end else if (reg_req.wr && reg_req.addr == e1ac_pkg::ADDR_IRQ_ENABLE) begin
      irq_enable <= reg_req.wdata[e1ac_pkg::IRQ_BITS-1:0];
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (!reg_req.rd) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.addr == e1ac_pkg::ADDR_ALARM_CTRL) begin
      reg_rdata <= alarm_ctrl;
    end else if (reg_req.addr == e1ac_pkg::ADDR_BP_SIG_CTRL) begin
      reg_rdata <= bp_sig_ctrl;
    end else if (reg_req.addr == e1ac_pkg::ADDR_LOOP_MON) begin
      reg_rdata <= loop_mon;
    end else if (reg_req.addr == e1ac_pkg::ADDR_IRQ_STATUS) begin
      reg_rdata <= {4'h0, irq_status};
    end else if (reg_req.addr == e1ac_pkg::ADDR_IRQ_ENABLE) begin
      reg_rdata <= {4'h0, irq_enable};
    end else if (reg_req.addr == e1ac_pkg::ADDR_TX_MONITOR) begin
      reg_rdata <= tx_channel_monitor;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // Transmit channel monitor
  // ==========================================================
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_channel_monitor <= 8'h00;
    end else if (tx_chan_valid && tx_chan_num == tx_monitor_select) begin
      tx_channel_monitor <= tx_chan_byte;
    end
  end

  // ==========================================================
  // Received line synchronisation and carrier loss
  // ==========================================================
  e1ac_pkg::e1ac_line_s rx_line_sync;
  logic [11:0]          zero_count;
  logic [11:0]          zero_limit;
  logic                 rx_is_zero;

  e1ac_sync3 u_rx_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in (rx_line_in),
    .sync_out (rx_line_sync)
  );

  assign zero_limit = carrier_loss_long_criterion ? e1ac_pkg::CL_ZEROS_LONG
                                                  : e1ac_pkg::CL_ZEROS_SHORT;
  assign rx_is_zero = !rx_line_sync.pos && !rx_line_sync.neg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      zero_count <= 12'h000;
    end else if (rx_bit_strobe) begin
      if (!rx_is_zero) begin
        zero_count <= 12'h000;
      end else if (zero_count < zero_limit) begin
        zero_count <= zero_count + 12'h001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_carrier_loss <= 1'b0;
    end else begin
      rx_carrier_loss <= (zero_count >= zero_limit);
    end
  end

  // ==========================================================
  // CRC4 multiframe search timer
  // ==========================================================
  logic [26:0] mf_timer;
  logic        mf_late;
  logic        mf_give_up;
  logic        mf_searching;

  assign mf_searching = rx_crc4_on && !rx_frame_loss && !rx_mf_sync;

  // Timer runs from frame alignment until multiframe sync
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mf_timer <= '0;
    end else if (!mf_searching) begin
      mf_timer <= '0;
    end else if (mf_timer < 27'(MF_GIVE_UP_CYCLES)) begin
      mf_timer <= mf_timer + 27'd1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mf_late    <= 1'b0;
      mf_give_up <= 1'b0;
    end else begin
      mf_late    <= mf_searching && mf_timer >= 27'(MF_FIND_CYCLES);
      mf_give_up <= mf_searching && mf_timer >= 27'(MF_GIVE_UP_CYCLES);
    end
  end

  // ==========================================================
  // Automatic alarm generation
  // ==========================================================
  logic rx_defect;
  logic next_ais;
  logic next_rai;

  assign rx_defect = rx_frame_loss || rx_ais_detect || rx_carrier_loss;
  assign next_ais  = alarm_ctrl[e1ac_pkg::BIT_AUTO_AIS] && rx_defect;
  assign next_rai  = (alarm_ctrl[e1ac_pkg::BIT_AUTO_RAI] && (rx_defect || mf_late))
                     || mf_give_up;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_ais_send <= 1'b0;
      tx_rai_send <= 1'b0;
    end else begin
      tx_ais_send <= next_ais;
      tx_rai_send <= next_rai;
    end
  end

  // ==========================================================
  // Interrupt status
  // ==========================================================
  logic cl_prev;
  logic mf_prev;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cl_prev <= 1'b0;
      mf_prev <= 1'b0;
    end else begin
      cl_prev <= rx_carrier_loss;
      mf_prev <= mf_give_up;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[e1ac_pkg::IRQ_CARRIER_LOSS] = rx_carrier_loss && !cl_prev;
    irq_event[e1ac_pkg::IRQ_AIS_START]    = next_ais && !tx_ais_send;
    irq_event[e1ac_pkg::IRQ_RAI_START]    = next_rai && !tx_rai_send;
    irq_event[e1ac_pkg::IRQ_MF_TIMEOUT]   = mf_give_up && !mf_prev;
  end

  assign irq_clear = (reg_req.wr && reg_req.addr == e1ac_pkg::ADDR_IRQ_CLEAR)
                     ? reg_req.wdata[e1ac_pkg::IRQ_BITS-1:0] : '0;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_status & ~irq_clear) | irq_event) & irq_enable);
    end
  end

  // ==========================================================
  // Line-side loopbacks and all-ones generation
  // ==========================================================
  logic ones_polarity;

  // Alternate mark polarity for all ones at master clock rate
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ones_polarity <= 1'b0;
    end else if (mclk_strobe) begin
      ones_polarity <= !ones_polarity;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_line_out <= '0;
    end else if (line_all_ones_force) begin
      if (mclk_strobe) begin
        tx_line_out.pos <= !ones_polarity;
        tx_line_out.neg <= ones_polarity;
      end
    end else if (remote_loop) begin
      tx_line_out <= rx_line_sync;
    end else begin
      tx_line_out <= tx_formatter_in;
    end
  end

  // Local loop sends transmitted data through the attenuator
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      jitter_att_in <= '0;
    end else if (local_loop) begin
      jitter_att_in <= tx_formatter_in;
    end else begin
      jitter_att_in <= rx_line_sync;
    end
  end

  // Receive framer always sees the attenuator output; remote loop keeps it fed
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_framer_out <= '0;
    end else begin
      rx_framer_out <= jitter_att_out;
    end
  end

  // ==========================================================
  // Backplane data paths
  // ==========================================================
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_data_out <= 1'b0;
    end else if (tx_hw_signaling_insert && tx_sig_slot
                 && (!tx_block_reg_function || tx_block_bit)) begin
      tx_data_out <= tx_signaling_in;
    end else if (tx_idle_mark && tx_idle_reg_function) begin
      tx_data_out <= rx_serial_out;
    end else if (tx_idle_mark) begin
      tx_data_out <= tx_idle_code_bit;
    end else begin
      tx_data_out <= tx_serial_in;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_channel_block_out <= 1'b0;
    end else begin
      tx_channel_block_out <= !tx_block_reg_function && tx_block_bit;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_serial_out <= 1'b0;
    end else if (rx_signaling_reinsert && rx_sig_slot) begin
      rx_serial_out <= rx_sig_bit;
    end else begin
      rx_serial_out <= rx_data_in;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_elastic_store_on     <= 1'b0;
      tx_backplane_clock_rate <= 1'b0;
    end else begin
      tx_elastic_store_on     <= bp_sig_ctrl[e1ac_pkg::BIT_TX_ES_ON];
      tx_backplane_clock_rate <= bp_sig_ctrl[e1ac_pkg::BIT_TX_BP_RATE];
    end
  end
endmodule : e1ac_control
`default_nettype wire

/* e1ac_pkg.sv */
// Package: register map, field positions, reset values and timing for E1 alarm/loopback control
package e1ac_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_ALARM_CTRL  = 8'h1A;
  localparam logic [7:0] ADDR_BP_SIG_CTRL = 8'h1B;
  localparam logic [7:0] ADDR_LOOP_MON    = 8'hA8;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'hB0;
  localparam logic [7:0] ADDR_IRQ_CLEAR   = 8'hB1;
  localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'hB2;
  localparam logic [7:0] ADDR_TX_MONITOR  = 8'hB3;

  // Reset values
  localparam logic [7:0] RST_ALARM_CTRL  = 8'h00;
  localparam logic [7:0] RST_BP_SIG_CTRL = 8'h00;
  localparam logic [7:0] RST_LOOP_MON    = 8'h00;
  localparam logic [7:0] RST_IRQ         = 8'h00;

  // Alarm control fields
  localparam int BIT_AUTO_AIS = 5;
  localparam int BIT_AUTO_RAI = 4;
  // Backplane/signaling control fields
  localparam int BIT_TX_ES_ON     = 7;
  localparam int BIT_TX_BLOCK_FN  = 6;
  localparam int BIT_TX_IDLE_FN   = 5;
  localparam int BIT_UNASSIGNED   = 4;
  localparam int BIT_RX_SIG_REINS = 3;
  localparam int BIT_TX_HW_SIG    = 2;
  localparam int BIT_TX_BP_RATE   = 1;
  localparam int BIT_CL_LONG      = 0;
  // Loopback/monitor fields
  localparam int BIT_REMOTE_LOOP  = 7;
  localparam int BIT_LOCAL_LOOP   = 6;
  localparam int BIT_LINE_ONES    = 5;
  localparam int MON_SEL_MSB      = 4;
  localparam int MON_SEL_LSB      = 0;
  // Interrupt status fields
  localparam int IRQ_CARRIER_LOSS = 0;
  localparam int IRQ_AIS_START    = 1;
  localparam int IRQ_RAI_START    = 2;
  localparam int IRQ_MF_TIMEOUT   = 3;
  localparam int IRQ_BITS         = 4;

  // Carrier loss zero counts
  localparam logic [11:0] CL_ZEROS_SHORT = 12'h0FF;
  localparam logic [11:0] CL_ZEROS_LONG  = 12'h800;

  // Multiframe search times
  localparam int CLK_PERIOD_NS     = 4;
  localparam int MF_FIND_MS        = 128;
  localparam int MF_GIVE_UP_MS     = 400;
  localparam int MF_FIND_CYCLES    = (MF_FIND_MS * 1000000) / CLK_PERIOD_NS;
  localparam int MF_GIVE_UP_CYCLES = (MF_GIVE_UP_MS * 1000000) / CLK_PERIOD_NS;

  typedef struct packed {
    logic pos;
    logic neg;
  } e1ac_line_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } e1ac_req_s;
endpackage : e1ac_pkg

/* e1ac_sync3.sv */
// Three-stage synchroniser for the received line pair
`timescale 1ns/100ps
`default_nettype none
module e1ac_sync3 (
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  input  wire e1ac_pkg::e1ac_line_s async_in,
  output var  e1ac_pkg::e1ac_line_s sync_out
);
  e1ac_pkg::e1ac_line_s stage1;
  e1ac_pkg::e1ac_line_s stage2;
  e1ac_pkg::e1ac_line_s stage3;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept a change only once the last two stages agree
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_out <= '0;
    end else if (stage2 == stage3) begin
      sync_out <= stage3;
    end
  end
endmodule : e1ac_sync3
`default_nettype wire

/* e1ac_line_model.sv */
// Line-side partner: receive line source and external jitter attenuator
`timescale 1ns/100ps
`default_nettype none
module e1ac_line_model (
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  input  wire logic                 line_zeros,
  output var  logic                 rx_bit_strobe,
  output var  logic                 mclk_strobe,
  output var  e1ac_pkg::e1ac_line_s rx_line_in,
  input  wire e1ac_pkg::e1ac_line_s jitter_att_in,
  output var  e1ac_pkg::e1ac_line_s jitter_att_out
);
  logic [1:0] phase;
  logic       mark;
  // ==========
  // Line bits, one every four core cycles, marks in alternating polarity
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 2'h0;
      mark <= 1'b0;
      rx_bit_strobe <= 1'b0;
      mclk_strobe <= 1'b0;
      rx_line_in <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
      rx_bit_strobe <= (phase == 2'h3);
      mclk_strobe <= (phase == 2'h1);
      if (phase == 2'h3) begin
        mark <= ~mark;
        rx_line_in <= line_zeros ? 2'h0 : {mark, ~mark};
      end
    end
  end
  // ==========
  // Attenuator: one cycle of delay
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      jitter_att_out <= 2'h0;
    end else begin
      jitter_att_out <= jitter_att_in;
    end
  end
endmodule : e1ac_line_model
`default_nettype wire

/* e1ac_monitor.sv */
// Checker on the ports of the control block
`timescale 1ns/100ps
`default_nettype none
module e1ac_monitor (
  input wire logic                 core_clk,
  input wire logic                 reset_n,
  input wire e1ac_pkg::e1ac_req_s  reg_req,
  input wire logic [7:0]           reg_rdata,
  input wire logic                 rx_frame_loss,
  input wire logic                 rx_ais_detect,
  input wire logic                 tx_ais_send,
  input wire logic                 tx_rai_send,
  input wire logic                 tx_elastic_store_on,
  input wire logic                 tx_backplane_clock_rate,
  input wire e1ac_pkg::e1ac_line_s tx_formatter_in,
  input wire e1ac_pkg::e1ac_line_s tx_line_out,
  input wire e1ac_pkg::e1ac_line_s jitter_att_in,
  input wire e1ac_pkg::e1ac_line_s jitter_att_out,
  input wire e1ac_pkg::e1ac_line_s rx_framer_out
);
  logic [7:0] ac, bp, lm;
  logic       cause;
  assign cause = rx_frame_loss | rx_ais_detect;
  // ==========
  // Shadow copies of the control registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ac <= 8'h00;
      bp <= 8'h00;
      lm <= 8'h00;
    end else if (reg_req.wr) begin
      if (reg_req.addr == e1ac_pkg::ADDR_ALARM_CTRL) ac <= reg_req.wdata;
      if (reg_req.addr == e1ac_pkg::ADDR_BP_SIG_CTRL) bp <= reg_req.wdata;
      if (reg_req.addr == e1ac_pkg::ADDR_LOOP_MON) lm <= reg_req.wdata;
    end
  end
  // ==========
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence bp_read_s;
    reg_req.rd && reg_req.addr == e1ac_pkg::ADDR_BP_SIG_CTRL;
  endsequence
  sequence lm_read_s;
    reg_req.rd && reg_req.addr == e1ac_pkg::ADDR_LOOP_MON;
  endsequence
  ais_auto_a: assert property (ac[5] && cause |=> tx_ais_send)
    else $error("auto ais not sent");
  ais_gate_a: assert property (tx_ais_send |-> $past(ac[5]))
    else $error("ais sent while disabled");
  rai_auto_a: assert property (ac[4] && cause |=> tx_rai_send)
    else $error("auto rai not sent");
  rdata_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  bp_read_a: assert property (bp_read_s |=> reg_rdata == $past(bp))
    else $error("control readback wrong");
  lm_read_a: assert property (lm_read_s |=> reg_rdata == $past(lm))
    else $error("loop readback wrong");
  ctrl_copy_a: assert property ({tx_elastic_store_on, tx_backplane_clock_rate} ==
    $past({bp[7], bp[1]})) else $error("control copies wrong");
  framer_feed_a: assert property ($past(reset_n) |-> rx_framer_out == $past(jitter_att_out))
    else $error("framer not fed from attenuator");
  local_loop_a: assert property (lm[6] |=> jitter_att_in == $past(tx_formatter_in))
    else $error("local loop data wrong");
  ones_force_a: assert property (lm[5] ##1 lm[5] |=> tx_line_out.pos != tx_line_out.neg)
    else $error("line ones missing");
  line_normal_a: assert property (!lm[7] && !lm[5] |=>
    tx_line_out == $past(tx_formatter_in)) else $error("line not from formatter");
endmodule : e1ac_monitor
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the alarm, control and loopback block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin n_compared++; \
  if ((a) !== (e)) begin err_count++; \
  $display("mismatch %s expected %h seen %h", n, e, a); end end
module tb_top;
  logic core_clk, reset_n, irq, rx_frame_loss, rx_ais_detect, rx_crc4_on, rx_mf_sync;
  logic rx_bit_strobe, mclk_strobe, tx_serial_in, tx_signaling_in, tx_sig_slot;
  logic tx_block_bit, tx_idle_mark, tx_idle_code_bit, tx_data_out, tx_channel_block_out;
  logic rx_data_in, rx_sig_slot, rx_sig_bit, rx_serial_out, tx_chan_valid, line_zeros;
  logic tx_elastic_store_on, tx_backplane_clock_rate, tx_ais_send, tx_rai_send, rx_carrier_loss;
  logic [4:0] tx_chan_num;
  logic [7:0] tx_chan_byte, reg_rdata;
  e1ac_pkg::e1ac_req_s reg_req;
  e1ac_pkg::e1ac_line_s rx_line_in, tx_formatter_in, tx_line_out, rx_framer_out;
  e1ac_pkg::e1ac_line_s jitter_att_in, jitter_att_out;
  int err_count, n_compared, n;
  logic [7:0] pbp [8] = '{8'h00, 8'h08, 8'h04, 8'h44, 8'h44, 8'h00, 8'h20, 8'h00};
  logic [8:0] pv [8] = '{9'h126, 9'h126, 9'h0C0, 9'h0C0, 9'h0E0, 9'h018, 9'h014, 9'h0C0};
  logic [2:0] pe [8] = '{3'h7, 3'h6, 3'h4, 3'h0, 3'h4, 3'h4, 3'h5, 3'h0};
  e1ac_control #(.MF_FIND_CYCLES(20), .MF_GIVE_UP_CYCLES(60)) i_e1ac_control (.*);
  e1ac_line_model i_e1ac_line_model (.*);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ==========
  // Access tasks
  task automatic look(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask : look
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask : wr
  task automatic chkrd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1;
    `CHK("read data", e, reg_rdata)
  endtask : chkrd
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (50000) @(posedge core_clk);
    err_count++;
    finish_test();
  end
  // ==========
  // Tests
  initial begin
    reset_n = 1'b0;
    reg_req = '0;
    line_zeros = 1'b0;
    tx_formatter_in = 2'b10;
    {rx_frame_loss, rx_ais_detect, rx_crc4_on, rx_mf_sync} = 4'h0;
    {tx_serial_in, tx_signaling_in, tx_sig_slot, tx_block_bit, tx_idle_mark,
     tx_idle_code_bit, rx_data_in, rx_sig_slot, rx_sig_bit} = 9'h000;
    {tx_chan_valid, tx_chan_num, tx_chan_byte} = 14'h0000;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    chkrd(e1ac_pkg::ADDR_BP_SIG_CTRL, e1ac_pkg::RST_BP_SIG_CTRL);
    chkrd(e1ac_pkg::ADDR_LOOP_MON, e1ac_pkg::RST_LOOP_MON);
    wr(e1ac_pkg::ADDR_BP_SIG_CTRL, 8'hEF);
    chkrd(e1ac_pkg::ADDR_BP_SIG_CTRL, 8'hEF);
    wr(e1ac_pkg::ADDR_LOOP_MON, 8'hC5);
    chkrd(e1ac_pkg::ADDR_LOOP_MON, 8'hC5);
    wr(8'h55, 8'hFF);
    chkrd(8'h55, 8'h00);
    chkrd(e1ac_pkg::ADDR_IRQ_CLEAR, 8'h00);
    for (int v = 0; v < 2; v++) begin
      wr(e1ac_pkg::ADDR_BP_SIG_CTRL, v[0] ? 8'h00 : 8'h82);
      look(2);
      `CHK("ctrl", {2{~v[0]}}, {tx_elastic_store_on, tx_backplane_clock_rate})
    end
    // Backplane data paths for each data-path control bit
    for (int i = 0; i < 8; i++) begin
      wr(e1ac_pkg::ADDR_BP_SIG_CTRL, pbp[i]);
      @(posedge core_clk) {tx_serial_in, tx_signaling_in, tx_sig_slot, tx_block_bit,
        tx_idle_mark, tx_idle_code_bit, rx_data_in, rx_sig_slot, rx_sig_bit} <= pv[i];
      look(2);
      `CHK("path", pe[i], {tx_data_out, tx_channel_block_out, rx_serial_out})
    end
    // Loopbacks and line ones
    wr(e1ac_pkg::ADDR_LOOP_MON, 8'h00);
    look(2);
    `CHK("line", 2'b10, tx_line_out)
    wr(e1ac_pkg::ADDR_LOOP_MON, 8'h80);
    n = 0;
    repeat (16) begin
      look(1);
      if (tx_line_out === 2'b01) n++;
    end
    `CHK("remote", 1'b1, n > 0)
    wr(e1ac_pkg::ADDR_LOOP_MON, 8'h40);
    @(posedge core_clk) tx_formatter_in <= 2'b11;
    look(5);
    `CHK("local", 6'h3F, {jitter_att_in, rx_framer_out, tx_line_out})
    @(posedge core_clk) tx_formatter_in <= 2'b10;
    wr(e1ac_pkg::ADDR_LOOP_MON, 8'h20);
    look(6);
    n = 0;
    repeat (24) begin
      look(1);
      n += (tx_line_out === 2'b01) ? 1 : ((tx_line_out === 2'b10) ? 100 : 0);
    end
    `CHK("ones", 1212, n)
    // Channel monitor at the top channel number
    wr(e1ac_pkg::ADDR_LOOP_MON, 8'h1F);
    @(posedge core_clk) {tx_chan_valid, tx_chan_num, tx_chan_byte} <= 14'h3FA5;
    @(posedge core_clk) {tx_chan_valid, tx_chan_num, tx_chan_byte} <= 14'h2F5A;
    @(posedge core_clk) tx_chan_valid <= 1'b0;
    chkrd(e1ac_pkg::ADDR_TX_MONITOR, 8'hA5);
    // Automatic alarms and interrupt
    wr(e1ac_pkg::ADDR_IRQ_ENABLE, 8'h02);
    wr(e1ac_pkg::ADDR_ALARM_CTRL, 8'h30);
    for (int c = 1; c < 3; c++) begin
      @(posedge core_clk) {rx_frame_loss, rx_ais_detect} <= c[1:0];
      look(3);
      `CHK("alarms", 3'h7, {tx_ais_send, tx_rai_send, irq})
      @(posedge core_clk) {rx_frame_loss, rx_ais_detect} <= 2'b00;
      wr(e1ac_pkg::ADDR_IRQ_STATUS, 8'h00);
      chkrd(e1ac_pkg::ADDR_IRQ_STATUS, 8'h06);
      wr(e1ac_pkg::ADDR_IRQ_CLEAR, 8'h0F);
      chkrd(e1ac_pkg::ADDR_IRQ_STATUS, 8'h00);
      `CHK("irq clear", 1'b0, irq)
    end
    wr(e1ac_pkg::ADDR_IRQ_ENABLE, 8'h04);
    wr(e1ac_pkg::ADDR_ALARM_CTRL, 8'h20);
    @(posedge core_clk) rx_frame_loss <= 1'b1;
    look(3);
    `CHK("masked", 3'h4, {tx_ais_send, tx_rai_send, irq})
    @(posedge core_clk) rx_frame_loss <= 1'b0;
    // Carrier loss, short then long criterion
    for (int k = 0; k < 2; k++) begin
      wr(e1ac_pkg::ADDR_BP_SIG_CTRL, k[7:0]);
      @(posedge core_clk) line_zeros <= 1'b1;
      look(k ? 8000 : 960);
      `CHK("carrier early", 1'b0, rx_carrier_loss)
      look(k ? 240 : 120);
      `CHK("carrier", 2'b11, {rx_carrier_loss, tx_ais_send})
      @(posedge core_clk) line_zeros <= 1'b0;
      look(24);
      `CHK("carrier end", 1'b0, rx_carrier_loss)
    end
    // Multiframe search timeouts
    wr(e1ac_pkg::ADDR_ALARM_CTRL, 8'h10);
    @(posedge core_clk) rx_crc4_on <= 1'b1;
    look(10);
    `CHK("rai early", 1'b0, tx_rai_send)
    look(20);
    `CHK("rai find", 1'b1, tx_rai_send)
    wr(e1ac_pkg::ADDR_ALARM_CTRL, 8'h00);
    @(posedge core_clk) rx_crc4_on <= 1'b0;
    @(posedge core_clk) rx_crc4_on <= 1'b1;
    look(30);
    `CHK("rai off", 1'b0, tx_rai_send)
    look(40);
    `CHK("rai give up", 1'b1, tx_rai_send)
    @(posedge core_clk) rx_mf_sync <= 1'b1;
    look(3);
    `CHK("rai sync", 1'b0, tx_rai_send)
    finish_test();
  end
endmodule : tb_top
bind e1ac_control e1ac_monitor i_e1ac_monitor (.*);
`default_nettype wire
